/* hdl/mac_mult.sv */
`timescale 1ns/1ps
`include "mac_unit_regs.svh"
// signed 16x16 multiplier with optional rounding of the upper half
module mac_mult #(
    parameter int W = 16
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic round_en,
    output logic [2*W-1:0] prod
);
    logic [2*W-1:0] raw;
    always_comb begin
        raw = (2*W)'($signed(a) * $signed(b));
        prod = round_en ? raw + `MAC_ROUND_CONST : raw;
    end
endmodule

/* hdl/mac_pkg.sv */
package mac_pkg;
    typedef enum logic [2:0] {
        MAC_IDLE = 3'b000,
        MAC_EXT = 3'b001,
        MAC_READ = 3'b010,
        MAC_WORD = 3'b011,
        MAC_DONE = 3'b100
    } mac_state_t;
    typedef enum logic [1:0] {
        MAC_PTR_NONE = 2'b00,
        MAC_PTR_INC = 2'b01,
        MAC_PTR_DEC = 2'b10
    } mac_ptr_mod_t;
endpackage

/* hdl/mac_unit.sv */
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "mac_unit_regs.svh"
module mac_unit #(
    parameter int W = 16,
    parameter int AW = 8
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic START,
    input wire logic [2:0] OPCODE,
    input wire logic MEM_SRC,
    input wire logic [1:0] PTR_MOD,
    input wire logic [W-1:0] EXT_WORD,
    input wire logic EXT_REL,
    input wire logic [W-1:0] REL_BASE,
    input wire logic [W-1:0] MULTIPLIER_OPERAND_REG,
    input wire logic [7:0] STRING_LENGTH_REG,
    input wire logic [AW-1:0] ACCUMULATOR_POINTER,
    input wire logic [W:0] MEM_RDATA,
    input wire logic [W-1:0] ACC_RDATA,
    output logic BUSY,
    output logic DONE,
    output logic [W-1:0] MEM_ADDR,
    output logic MEM_RD,
    output logic [AW-1:0] ACC_ADDR,
    output logic ACC_WE,
    output logic [W-1:0] ACC_WDATA,
    output logic [W-1:0] PRODUCT_HIGH_REG,
    output logic [W-1:0] PRODUCT_LOW_REG,
    output logic [AW-1:0] PTR_OUT,
    output logic OVERFLOW_FLAG,
    output logic SIGN_FLAG,
    output logic ZERO_FLAG,
    output logic CARRY_FLAG,
    output logic TAG_FLAG
);
    if (W != 16) begin : g_chk_w
        $error("mac_unit supports W=16 only");
    end
    if (AW < 2) begin : g_chk_aw
        $error("mac_unit AW too small");
    end
    ////////////////////////////////////////////////////////////////
    mac_pkg::mac_state_t st_r, st_nxt;
    logic [2:0] op_r, op_nxt;
    logic mem_r, mem_nxt;
    logic [AW-1:0] aptr_r, aptr_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic carry_r, carry_nxt;
    logic zacc_r, zacc_nxt;
    logic [W-1:0] ph_r, ph_nxt, pl_r, pl_nxt, wd_r, wd_nxt, ma_r, ma_nxt;
    logic busy_r, busy_nxt, done_r, done_nxt, mrd_r, mrd_nxt, we_r, we_nxt;
    logic of_r, of_nxt, sf_r, sf_nxt, zf_r, zf_nxt, cf_r, cf_nxt, tf_r, tf_nxt;
    logic [W-1:0] operand;
    logic round_en;
    logic [2*W-1:0] prod;
    logic [W:0] sum;
    logic first_r, first_nxt;
    logic [AW-1:0] acc_addr_r, acc_addr_nxt;
    logic [W-1:0] addend;

    function automatic logic is_add(input logic [2:0] op);
        return op == `MAC_OP_MAPL || op == `MAC_OP_MAPLS;
    endfunction

    ////////////////////////////////////////////////////////////////
    // product path
    assign operand = mem_r ? MEM_RDATA[W-1:0] : ACC_RDATA;
    assign round_en = (op_r == `MAC_OP_ROUNDED_MEM_MULTIPLY) || (op_r == `MAC_OP_STRING_MULTIPLY); // [RULE1] [RULE7]
    // product-low enters the lowest word only, upper words take the carry
    assign addend = first_r ? pl_r : '0;

    mac_mult #(.W(W)) u_mult (
        .a(MULTIPLIER_OPERAND_REG),
        .b(operand),
        .round_en(round_en),
        .prod(prod)
    );

    ////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        mem_nxt = mem_r;
        aptr_nxt = aptr_r;
        cnt_nxt = cnt_r;
        carry_nxt = carry_r;
        zacc_nxt = zacc_r;
        ph_nxt = ph_r;
        pl_nxt = pl_r;
        wd_nxt = wd_r;
        ma_nxt = ma_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        mrd_nxt = 1'b0;
        we_nxt = 1'b0;
        of_nxt = of_r;
        sf_nxt = sf_r;
        zf_nxt = zf_r;
        cf_nxt = cf_r;
        tf_nxt = tf_r;
        first_nxt = first_r;
        sum = {1'b0, ACC_RDATA} + {1'b0, addend} + {{W{1'b0}}, carry_r};
        unique case (st_r)
            mac_pkg::MAC_IDLE: begin
                if (START && OPCODE != `MAC_OP_NONE) begin
                    op_nxt = OPCODE;
                    first_nxt = 1'b1;
                    busy_nxt = 1'b1;
                    carry_nxt = 1'b0;
                    zacc_nxt = 1'b1;
                    aptr_nxt = ACCUMULATOR_POINTER;
                    // string multiply always takes its operand from the accumulator
                    mem_nxt = (MEM_SRC && OPCODE != `MAC_OP_STRING_MULTIPLY) || (OPCODE == `MAC_OP_ROUNDED_MEM_MULTIPLY); // [RULE5]
                    if (!MEM_SRC && OPCODE == `MAC_OP_MAPL) begin
                        if (PTR_MOD == mac_pkg::MAC_PTR_INC) aptr_nxt = ACCUMULATOR_POINTER + AW'(1); // [RULE12]
                        else if (PTR_MOD == mac_pkg::MAC_PTR_DEC) aptr_nxt = ACCUMULATOR_POINTER - AW'(1); // [RULE12]
                    end
                    // word count of the string is length plus two
                    cnt_nxt = (OPCODE == `MAC_OP_STRING_MULTIPLY || OPCODE == `MAC_OP_MAPLS) ?
                        {1'b0, STRING_LENGTH_REG} + {1'b0, `MAC_STR_EXTRA} - 9'h001 : 9'h000; // [RULE6]
                    if ((MEM_SRC && OPCODE != `MAC_OP_STRING_MULTIPLY) || OPCODE == `MAC_OP_ROUNDED_MEM_MULTIPLY) begin
                        st_nxt = mac_pkg::MAC_EXT;
                    end else begin
                        st_nxt = mac_pkg::MAC_READ;
                    end
                end
            end
            mac_pkg::MAC_EXT: begin
                ma_nxt = EXT_REL ? EXT_WORD + REL_BASE : EXT_WORD; // [RULE4]
                mrd_nxt = 1'b1;
                st_nxt = mac_pkg::MAC_READ;
            end
            mac_pkg::MAC_READ: begin
                // operand presented this cycle; the multiply runs on the word
                st_nxt = mac_pkg::MAC_WORD;
                if (op_r == `MAC_OP_ROUNDED_MEM_MULTIPLY || op_r == `MAC_OP_STRING_MULTIPLY) begin
                    ph_nxt = prod[2*W-1:W]; // [RULE2] [RULE5] [RULE7]
                    if (mem_r) tf_nxt = MEM_RDATA[`MAC_TAG_BIT]; // [RULE3]
                    st_nxt = mac_pkg::MAC_DONE;
                end else if (is_add(op_r)) begin
                    ph_nxt = prod[2*W-1:W]; // [RULE8]
                    pl_nxt = prod[W-1:0]; // [RULE8]
                    if (mem_r) tf_nxt = MEM_RDATA[`MAC_TAG_BIT]; // [RULE11]
                end
            end
            mac_pkg::MAC_WORD: begin
                // shared accumulator port: wait out the write-back of the previous word
                if (!we_r) begin
                    wd_nxt = sum[W-1:0]; // [RULE8] [RULE10]
                    we_nxt = 1'b1; // [RULE10]
                    first_nxt = 1'b0;
                    carry_nxt = sum[W];
                    zacc_nxt = zacc_r && (sum[W-1:0] == '0);
                    if (cnt_r == 9'h000) begin
                        cf_nxt = sum[W]; // [RULE11]
                        sf_nxt = sum[W-1]; // [RULE11]
                        zf_nxt = zacc_r && (sum[W-1:0] == '0); // [RULE11]
                        of_nxt = (ACC_RDATA[W-1] == addend[W-1]) && (sum[W-1] != ACC_RDATA[W-1]); // [RULE11]
                        st_nxt = mac_pkg::MAC_DONE;
                    end else begin
                        cnt_nxt = cnt_r - 9'h001;
                        aptr_nxt = aptr_r + AW'(1);
                    end
                end
            end
            mac_pkg::MAC_DONE: begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                st_nxt = mac_pkg::MAC_IDLE;
            end
            default: st_nxt = mac_pkg::MAC_IDLE;
        endcase
        // write cycle points at the word just summed, otherwise at the next read
        acc_addr_nxt = we_nxt ? aptr_r : aptr_nxt;
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r <= mac_pkg::MAC_IDLE;
            op_r <= 3'h0;
            mem_r <= 1'b0;
            aptr_r <= '0;
            cnt_r <= 9'h000;
            carry_r <= 1'b0;
            zacc_r <= 1'b1;
            ph_r <= 16'h0000;
            pl_r <= 16'h0000;
            wd_r <= 16'h0000;
            ma_r <= 16'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            mrd_r <= 1'b0;
            we_r <= 1'b0;
            of_r <= 1'b0;
            sf_r <= 1'b0;
            zf_r <= 1'b0;
            cf_r <= 1'b0;
            tf_r <= 1'b0;
            first_r <= 1'b0;
            acc_addr_r <= '0;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            mem_r <= mem_nxt;
            aptr_r <= aptr_nxt;
            cnt_r <= cnt_nxt;
            carry_r <= carry_nxt;
            zacc_r <= zacc_nxt;
            ph_r <= ph_nxt;
            pl_r <= pl_nxt;
            wd_r <= wd_nxt;
            ma_r <= ma_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            mrd_r <= mrd_nxt;
            we_r <= we_nxt;
            of_r <= of_nxt;
            sf_r <= sf_nxt;
            zf_r <= zf_nxt;
            cf_r <= cf_nxt;
            tf_r <= tf_nxt;
            first_r <= first_nxt;
            acc_addr_r <= acc_addr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign BUSY = busy_r;
    assign DONE = done_r;
    assign MEM_ADDR = ma_r;
    assign MEM_RD = mrd_r;
    assign ACC_ADDR = acc_addr_r;
    assign ACC_WE = we_r;
    assign ACC_WDATA = wd_r;
    assign PRODUCT_HIGH_REG = ph_r;
    assign PRODUCT_LOW_REG = pl_r;
    assign PTR_OUT = aptr_r;
    assign OVERFLOW_FLAG = of_r;
    assign SIGN_FLAG = sf_r;
    assign ZERO_FLAG = zf_r;
    assign CARRY_FLAG = cf_r;
    assign TAG_FLAG = tf_r;

    ////////////////////////////////////////////////////////////////
    rounded_mem_multiply_flags_a: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE2]
        (st_r == mac_pkg::MAC_READ && op_r == `MAC_OP_ROUNDED_MEM_MULTIPLY) |=> $stable(cf_r) && $stable(of_r) && $stable(pl_r))
        else $error("rounded multiply changed flags or low product");
    rounded_mem_multiply_tag_a: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE3]
        (st_r == mac_pkg::MAC_READ && op_r == `MAC_OP_ROUNDED_MEM_MULTIPLY) |=> tf_r == $past(MEM_RDATA[16]))
        else $error("tag not taken from memory word");
    rounded_mem_multiply_round_a: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE1]
        (st_r == mac_pkg::MAC_READ && op_r == `MAC_OP_ROUNDED_MEM_MULTIPLY) |=>
        ph_r == 16'((32'($signed(MULTIPLIER_OPERAND_REG) * $signed($past(MEM_RDATA[15:0]))) + 32'h8000) >> 16))
        else $error("rounded product wrong");
    string_multiply_nowrite_a: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE5]
        (st_r == mac_pkg::MAC_READ && op_r == `MAC_OP_STRING_MULTIPLY) |=> !we_r ##1 !we_r)
        else $error("string multiply wrote accumulator");
    mapl_write_a: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE8]
        (st_r == mac_pkg::MAC_WORD && op_r == `MAC_OP_MAPL && !we_r) |=> we_r && wd_r == $past(sum[15:0]))
        else $error("multiply-add result missing");
    mapl_done_a: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE10]
        (st_r == mac_pkg::MAC_WORD && cnt_r == 9'h000 && !we_r) |=> ##1 done_r)
        else $error("multiply-add did not finish");
    mapl_carry_a: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE11]
        (st_r == mac_pkg::MAC_WORD && cnt_r == 9'h000 && !we_r) |=> cf_r == $past(sum[16]))
        else $error("carry flag wrong");
    ext_addr_a: assert property (@(posedge CLK) disable iff (!ARST_N) // [RULE4]
        (st_r == mac_pkg::MAC_EXT) |=> mrd_r && ma_r == $past(EXT_REL ? EXT_WORD + REL_BASE : EXT_WORD))
        else $error("operand address wrong");
endmodule

/* hdl/mac_unit_regs.svh */
// Operation
// RULE1: rounded memory multiply adds the rounding constant to the full product, then takes the upper half
// RULE2: rounded memory multiply writes the product-high register only, arithmetic flags unchanged
// RULE3: rounded memory multiply updates the tag from bit sixteen of the memory word
// RULE4: memory forms carry a second word: direct address or long relative offset
// RULE5: string multiply leaves the source string alone, ignores product-low, writes product-high only
// RULE6: accumulator string length is the string-length register value plus two words
// RULE7: string multiply rounds the upper sixteen result bits
// RULE8: word multiply-add loads product high and low, then adds product-low to accumulator
// RULE9: software respects the multiply-add restrictions when background interrupts run
// RULE10: string multiply-add adds product-low into the accumulator string and writes it back
// RULE11: multiply-add forms set overflow, sign, zero, carry; tag only for memory source
// RULE12: register multiply-add applies pointer pre-increment or pre-decrement before reading operands
`ifndef MAC_UNIT_REGS_SVH
`define MAC_UNIT_REGS_SVH
`define MAC_ROUND_CONST 32'h0000_8000
`define MAC_STR_EXTRA 8'h02
`define MAC_TAG_BIT 16
`define MAC_OP_NONE 3'h0
`define MAC_OP_ROUNDED_MEM_MULTIPLY 3'h1
`define MAC_OP_STRING_MULTIPLY 3'h2
`define MAC_OP_MAPL 3'h3
`define MAC_OP_MAPLS 3'h4
`endif

/* tb/mac_partner.sv */
`timescale 1ns/1ps
// data memory and accumulator file facing the multiply unit
module mac_partner #(
    parameter int W = 16,
    parameter int AW = 8
) (
    input wire logic CLK,
    input wire logic [W-1:0] MEM_ADDR,
    input wire logic [AW-1:0] ACC_ADDR,
    input wire logic ACC_WE,
    input wire logic [W-1:0] ACC_WDATA,
    output logic [W:0] MEM_RDATA,
    output logic [W-1:0] ACC_RDATA
);
    logic [W-1:0] acc [2**AW];
    initial begin
        for (int i = 0; i < 2**AW; i++) begin
            acc[i] = W'(i * 971 + 7);
        end
    end
    // memory word with its tag bit, a fixed pattern per address
    assign MEM_RDATA = {^MEM_ADDR, MEM_ADDR * 16'h9e37 ^ 16'h5a5a};
    assign ACC_RDATA = acc[ACC_ADDR];
    always @(posedge CLK) begin
        if (ACC_WE) begin
            acc[ACC_ADDR] <= ACC_WDATA;
        end
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk = 0, arst_n = 0, start = 0, mem_src = 0, ext_rel = 0;
    logic [2:0] opcode = 3'h0;
    logic [1:0] ptr_mod = 2'h0;
    logic [15:0] ext_word = 16'h0, rel_base = 16'h0, mr = 16'h0, acc_rdata, acc_wdata, mem_addr, ph, pl;
    logic [7:0] slen = 8'h0, ptr = 8'h0, acc_addr, ptr_out;
    logic [16:0] mem_rdata;
    logic busy, done, mem_rd, acc_we, of_f, sf_f, zf_f, cf_f, tag_f;
    logic [15:0] e_ph = 16'h0, e_pl = 16'h0, e_ea = 16'h0;
    logic e_of = 0, e_sf = 0, e_zf = 0, e_cf = 0, e_tag = 0;
    logic [31:0] seed = 32'ha161;
    int miscompares = 0, comparisons = 0, rd_cnt = 0, wr_cnt = 0;
    always #50 clk = ~clk;
    mac_unit uut (.CLK(clk), .ARST_N(arst_n), .START(start), .OPCODE(opcode), .MEM_SRC(mem_src),
        .PTR_MOD(ptr_mod), .EXT_WORD(ext_word), .EXT_REL(ext_rel), .REL_BASE(rel_base),
        .MULTIPLIER_OPERAND_REG(mr), .STRING_LENGTH_REG(slen), .ACCUMULATOR_POINTER(ptr),
        .MEM_RDATA(mem_rdata), .ACC_RDATA(acc_rdata), .BUSY(busy), .DONE(done), .MEM_ADDR(mem_addr),
        .MEM_RD(mem_rd), .ACC_ADDR(acc_addr), .ACC_WE(acc_we), .ACC_WDATA(acc_wdata), .PRODUCT_HIGH_REG(ph),
        .PRODUCT_LOW_REG(pl), .PTR_OUT(ptr_out), .OVERFLOW_FLAG(of_f), .SIGN_FLAG(sf_f), .ZERO_FLAG(zf_f),
        .CARRY_FLAG(cf_f), .TAG_FLAG(tag_f));
    mac_partner u_mem (.CLK(clk), .MEM_ADDR(mem_addr), .ACC_ADDR(acc_addr), .ACC_WE(acc_we),
        .ACC_WDATA(acc_wdata), .MEM_RDATA(mem_rdata), .ACC_RDATA(acc_rdata));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] mulf(input logic [15:0] a, input logic [15:0] b);
        logic signed [31:0] q;
        q = $signed(a) * $signed(b);
        return q;
    endfunction
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk16(nm, {15'h0, e}, {15'h0, g});
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (mem_rd === 1'b1) begin
            rd_cnt++;
            chk16("mem_addr", e_ea, mem_addr);
        end
        if (acc_we === 1'b1) wr_cnt++;
    end
    task automatic do_op(input logic [2:0] op, input logic ms, input logic [1:0] pm, input logic [15:0] m);
        logic [15:0] ew, rb, src, b, a;
        logic [16:0] md, s;
        logic [31:0] p;
        logic [7:0] p2, pt, sl, ept;
        logic [15:0] ex [8];
        logic c, z, msrc;
        int n;
        ew = rnd();
        rb = rnd();
        sl = {6'h0, ew[2:1]};
        pt = 8'(8 + rnd() % 190);
        e_ea = ew[0] ? ew + rb : ew;
        md = {^e_ea, e_ea * 16'h9e37 ^ 16'h5a5a};
        msrc = (ms || op == 3'h1) && op != 3'h2;
        p2 = (op == 3'h3 && !ms) ? (pm == 2'h1 ? pt + 8'h1 : pm == 2'h2 ? pt - 8'h1 : pt) : pt;
        src = msrc ? md[15:0] : u_mem.acc[p2];
        p = mulf(m, src);
        if (op <= 3'h2) p = p + 32'h8000;
        e_ph = p[31:16];
        if (op >= 3'h3) e_pl = p[15:0];
        if (msrc) e_tag = md[16];
        n = op == 3'h4 ? int'(sl) + 2 : op == 3'h3 ? 1 : 0;
        c = 0;
        z = 1;
        ex[0] = u_mem.acc[p2];
        for (int k = 0; k < n; k++) begin
            a = u_mem.acc[8'(p2 + k)];
            b = k == 0 ? p[15:0] : 16'h0;
            s = a + b + c;
            ex[k] = s[15:0];
            e_of = a[15] ^ b[15] ^ s[15] ^ s[16];
            e_sf = s[15];
            c = s[16];
            z = z & (s[15:0] == 16'h0);
        end
        if (n > 0) {e_cf, e_zf} = {c, z};
        ept = n > 0 ? 8'(p2 + n - 1) : p2;
        rd_cnt = 0;
        wr_cnt = 0;
        @(posedge clk);
        start <= 1;
        opcode <= op;
        mem_src <= ms;
        ptr_mod <= pm;
        ext_word <= ew;
        ext_rel <= ew[0];
        rel_base <= rb;
        mr <= m;
        slen <= sl;
        ptr <= pt;
        @(posedge clk);
        opcode <= 3'h2;
        repeat (40) begin
            @(posedge clk);
            start <= 0;
            #1;
            if (done === 1'b1) break;
        end
        chk1("done", 1'b1, done);
        chk1("busy", 1'b0, busy);
        chk16("ptr", 16'(ept), 16'(ptr_out));
        chk16("ph", e_ph, ph);
        chk16("pl", e_pl, pl);
        chk1("of", e_of, of_f);
        chk1("sf", e_sf, sf_f);
        chk1("zf", e_zf, zf_f);
        chk1("cf", e_cf, cf_f);
        chk1("tag", e_tag, tag_f);
        chk16("reads", 16'(msrc), 16'(rd_cnt));
        chk16("writes", 16'(n), 16'(wr_cnt));
        for (int k = 0; k < n; k++) chk16("acc", ex[k], u_mem.acc[8'(p2 + k)]);
        if (n == 0) chk16("src", ex[0], u_mem.acc[p2]);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #3000000;
        miscompares++;
        print_verdict();
    end
    initial begin
        logic [31:0] r;
        repeat (4) @(posedge clk);
        arst_n <= 1;
        do_op(3'h3, 0, 2'h1, 16'h8000);
        do_op(3'h3, 0, 2'h2, 16'h7fff);
        do_op(3'h4, 0, 2'h0, 16'hffff);
        do_op(3'h2, 0, 2'h0, 16'h8000);
        do_op(3'h1, 1, 2'h0, 16'h8000);
        @(posedge clk);
        start <= 1;
        opcode <= 3'h0;
        @(posedge clk);
        start <= 0;
        repeat (3) @(posedge clk);
        #1;
        chk1("busy", 1'b0, busy);
        // each op completes before the next, no background servicing
        repeat (80) begin
            r = rnd();
            do_op(3'(1 + r % 4), r[8], 2'(r[5:4] % 3), r[31:16]);
        end
        print_verdict();
    end
endmodule
